// ==== tsr_pkg.sv ====
// Package for the temperature result readout: constants and carrier types
package tsr_pkg;
   localparam logic [3:0]  DEV_ADDR_FIXED   = 4'h9;
   localparam logic [7:0]  PTR_TEMP_RESULT  = 8'h00;
   localparam logic [15:0] TEMP_RESULT_RST  = 16'h0000;
   localparam logic [7:0]  PTR_RST          = 8'h00;
   localparam int          CFG_RES_HI       = 14;
   localparam int          CFG_RES_LO       = 13;
   localparam int          CFG_PWRDN_BIT    = 8;
   localparam logic [1:0]  RES_9            = 2'h0;
   localparam logic [1:0]  RES_10           = 2'h1;
   localparam logic [1:0]  RES_11           = 2'h2;
   localparam logic [1:0]  RES_12           = 2'h3;
   localparam int          RESULT_LSB_12    = 4;

   // Conversion strobe from the measurement engine
   typedef struct packed {
      logic        valid;
      logic [11:0] value;
   } tsr_sample_type;

   // Open-drain SDA drive pair
   typedef struct packed {
      logic out;
      logic oe_n;
   } tsr_sda_type;
endpackage : tsr_pkg

// ==== tsr_readout.sv ====
// Temperature result register served to a two-wire bus master
//
// Behaviour
// - Latest conversion kept in 16-bit read-only two's complement register.
// - Result left-justified by resolution; unused low bits forced to zero.
// - Bit 15 carries the sign, one meaning negative.
// - At 12 bits, bit 4 weighs 1/16 degree, bit 8 one degree.
// - Reads never disturb measurement or other operations.
// - New conversion loads only when no result read is in progress.
// - Read address 1001 plus straps plus R/W one is acknowledged.
// - Upper byte first; master ACK requests lower byte.
// - NACK after lower byte; device releases SDA.
// - ACK after lower byte restarts output with fresh upper byte.
// - NACK after upper byte skips lower byte and releases SDA.
// - Result clears to zero at reset; wait a conversion time.
// - Power-down configuration still gets one conversion after power-up.
// - Writes to the result register are NACKed on every data byte.
// - Selector resets to the result register index.
// - Selector stays put across reads until rewritten.
// - Configuration bits 14:13 choose 9, 10, 11 or 12 bits.
// - Configuration bit 8 set means power-down, sensor disabled.
`timescale 1ns/1ps
`default_nettype none
module tsr_readout
   import tsr_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   scl_in,
   input  wire logic                   sda_in,
   output var  tsr_pkg::tsr_sda_type   sda_drive,
   input  wire logic [2:0]             strap_address_pins,
   input  wire logic [15:0]            config_word,
   input  wire tsr_pkg::tsr_sample_type sample_in,
   output logic                        conv_request,
   output logic [15:0]                 temperature_result,
   output logic [7:0]                  selector
);
   import tsr_pkg::*;

   // ---------------------------------------------------------------
   // Resolution mask
   // ---------------------------------------------------------------
   function automatic logic [15:0] res_mask(input logic [1:0] sel);
      logic [15:0] m;
      m = 16'hfff0;
      case (sel)
         RES_9:   m = 16'hff80;
         RES_10:  m = 16'hffc0;
         RES_11:  m = 16'hffe0;
         default: m = 16'hfff0;
      endcase
      return m;
   endfunction : res_mask

   // ---------------------------------------------------------------
   // Bus pin edge detection
   // ---------------------------------------------------------------
   logic scl_d_ff, sda_d_ff;
   logic nxt_scl_d, nxt_sda_d;
   logic scl_rise, scl_fall, start_cond, stop_cond;

   always_comb begin
      nxt_scl_d = scl_in;
      nxt_sda_d = sda_in;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= nxt_scl_d;
         sda_d_ff <= nxt_sda_d;
      end
   end

   assign scl_rise   = scl_in & ~scl_d_ff;
   assign scl_fall   = ~scl_in & scl_d_ff;
   assign start_cond = scl_in & scl_d_ff & sda_d_ff & ~sda_in;
   assign stop_cond  = scl_in & scl_d_ff & ~sda_d_ff & sda_in;

   // ---------------------------------------------------------------
   // Bus protocol machine
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK,
      ST_RD_BYTE, ST_RD_ACK
   } tsr_state_type;

   tsr_state_type state_ff, nxt_state;
   logic [2:0]  bit_cnt_ff, nxt_bit_cnt;
   logic [7:0]  shift_ff, nxt_shift;
   logic        sda_out_ff, nxt_sda_out;
   logic        lower_ff, nxt_lower;
   logic        first_wr_ff, nxt_first_wr;
   logic        ack_ok_ff, nxt_ack_ok;
   logic [15:0] shadow_ff, nxt_shadow;
   logic [7:0]  selector_ff, nxt_selector;
   logic        reading;
   // Set by the first address bit; hides the clock fall ending a start
   logic        armed_ff, nxt_armed;

   assign reading = (state_ff == ST_RD_BYTE) || (state_ff == ST_RD_ACK);

   always_comb begin
      nxt_state    = state_ff;
      nxt_bit_cnt  = bit_cnt_ff;
      nxt_shift    = shift_ff;
      nxt_sda_out  = sda_out_ff;
      nxt_lower    = lower_ff;
      nxt_first_wr = first_wr_ff;
      nxt_ack_ok   = ack_ok_ff;
      nxt_shadow   = shadow_ff;
      nxt_selector = selector_ff;
      nxt_armed    = armed_ff;
      if (stop_cond) begin
         nxt_state   = ST_IDLE;
         nxt_sda_out = 1'b1;
      end else if (start_cond) begin
         nxt_state   = ST_ADDR;
         nxt_armed   = 1'b0;
         nxt_bit_cnt = 3'h0;
         nxt_sda_out = 1'b1;
      end else begin
         case (state_ff)
            ST_IDLE: nxt_sda_out = 1'b1;
            ST_ADDR: begin
               if (scl_rise) begin
                  nxt_shift   = {shift_ff[6:0], sda_in};
                  nxt_bit_cnt = bit_cnt_ff + 3'h1;
                  nxt_armed   = 1'b1;
               end else if (scl_fall && bit_cnt_ff == 3'h0 && armed_ff) begin
                  if (shift_ff[7:1] == {DEV_ADDR_FIXED, strap_address_pins})
                  begin
                     nxt_sda_out = 1'b0;
                     nxt_state   = ST_ADDR_ACK;
                  end else begin
                     nxt_state = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (shift_ff[0]) begin
                     nxt_shadow = (selector_ff == PTR_TEMP_RESULT) ?
                                  temperature_result : 16'h0000;
                     nxt_shift   = nxt_shadow[15:8];
                     nxt_sda_out = nxt_shadow[15];
                     nxt_lower   = 1'b0;
                     nxt_state   = ST_RD_BYTE;
                  end else begin
                     nxt_sda_out  = 1'b1;
                     nxt_first_wr = 1'b1;
                     nxt_state    = ST_WR_BYTE;
                  end
                  nxt_bit_cnt = 3'h0;
               end
            end
            ST_WR_BYTE: begin
               if (scl_rise) begin
                  nxt_shift   = {shift_ff[6:0], sda_in};
                  nxt_bit_cnt = bit_cnt_ff + 3'h1;
               end else if (scl_fall && bit_cnt_ff == 3'h0) begin
                  nxt_ack_ok = 1'b0;
                  if (first_wr_ff) begin
                     nxt_selector = shift_ff;
                     nxt_ack_ok   = 1'b1;
                  end else if (selector_ff != PTR_TEMP_RESULT) begin
                     nxt_ack_ok = 1'b1;
                  end
                  nxt_sda_out  = ~nxt_ack_ok;
                  nxt_first_wr = 1'b0;
                  nxt_state    = ST_WR_ACK;
               end
            end
            ST_WR_ACK: begin
               if (scl_fall) begin
                  nxt_sda_out = 1'b1;
                  nxt_state   = ST_WR_BYTE;
               end
            end
            ST_RD_BYTE: begin
               if (scl_fall) begin
                  nxt_bit_cnt = bit_cnt_ff + 3'h1;
                  if (bit_cnt_ff == 3'h7) begin
                     nxt_sda_out = 1'b1;
                     nxt_state   = ST_RD_ACK;
                  end else begin
                     nxt_shift   = {shift_ff[6:0], 1'b0};
                     nxt_sda_out = shift_ff[6];
                  end
               end
            end
            ST_RD_ACK: begin
               if (scl_rise) begin
                  nxt_ack_ok = ~sda_in;
               end else if (scl_fall) begin
                  nxt_bit_cnt = 3'h0;
                  if (!ack_ok_ff) begin
                     nxt_sda_out = 1'b1;
                     nxt_state   = ST_IDLE;
                  end else if (!lower_ff) begin
                     nxt_shift   = shadow_ff[7:0];
                     nxt_sda_out = shadow_ff[7];
                     nxt_lower   = 1'b1;
                     nxt_state   = ST_RD_BYTE;
                  end else begin
                     nxt_shadow  = (selector_ff == PTR_TEMP_RESULT) ?
                                   temperature_result : 16'h0000;
                     nxt_shift   = nxt_shadow[15:8];
                     nxt_sda_out = nxt_shadow[15];
                     nxt_lower   = 1'b0;
                     nxt_state   = ST_RD_BYTE;
                  end
               end
            end
            default: begin
               nxt_state   = ST_IDLE;
               nxt_sda_out = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff    <= ST_IDLE;
         bit_cnt_ff  <= 3'h0;
         shift_ff    <= 8'h00;
         sda_out_ff  <= 1'b1;
         lower_ff    <= 1'b0;
         first_wr_ff <= 1'b0;
         ack_ok_ff   <= 1'b0;
         shadow_ff   <= TEMP_RESULT_RST;
         selector_ff <= PTR_RST;
         armed_ff    <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         bit_cnt_ff  <= nxt_bit_cnt;
         shift_ff    <= nxt_shift;
         sda_out_ff  <= nxt_sda_out;
         lower_ff    <= nxt_lower;
         first_wr_ff <= nxt_first_wr;
         ack_ok_ff   <= nxt_ack_ok;
         shadow_ff   <= nxt_shadow;
         selector_ff <= nxt_selector;
         armed_ff    <= nxt_armed;
      end
   end

   // ---------------------------------------------------------------
   // Result register and conversion request
   // ---------------------------------------------------------------
   logic [15:0] result_ff, nxt_result;
   logic        pend_ff, nxt_pend;
   logic [15:0] pend_val_ff, nxt_pend_val;
   logic        boot_ff, nxt_boot;
   logic [15:0] incoming;

   assign incoming = {sample_in.value, 4'h0} &
                     res_mask(config_word[CFG_RES_HI:CFG_RES_LO]);

   always_comb begin
      nxt_result   = result_ff;
      nxt_pend     = pend_ff;
      nxt_pend_val = pend_val_ff;
      nxt_boot     = 1'b0;
      if (sample_in.valid) begin
         nxt_pend     = 1'b1;
         nxt_pend_val = incoming;
      end
      if (!reading && (sample_in.valid || pend_ff)) begin
         nxt_result = sample_in.valid ? incoming : pend_val_ff;
         nxt_pend   = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         result_ff   <= TEMP_RESULT_RST;
         pend_ff     <= 1'b0;
         pend_val_ff <= TEMP_RESULT_RST;
         boot_ff     <= 1'b1;
      end else begin
         result_ff   <= nxt_result;
         pend_ff     <= nxt_pend;
         pend_val_ff <= nxt_pend_val;
         boot_ff     <= nxt_boot;
      end
   end

   logic conv_req_ff, nxt_conv_req;
   always_comb begin
      nxt_conv_req = ~config_word[CFG_PWRDN_BIT] | boot_ff;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         conv_req_ff <= 1'b0;
      end else begin
         conv_req_ff <= nxt_conv_req;
      end
   end

   assign temperature_result = result_ff;
   assign selector           = selector_ff;
   assign conv_request       = conv_req_ff;
   assign sda_drive.out      = 1'b0;
   assign sda_drive.oe_n     = sda_out_ff;
endmodule : tsr_readout
`default_nettype wire

// ==== tsr_readout_props.sv ====
// Concurrent checks on the readout ports
`timescale 1ns/1ps
`default_nettype none
module tsr_readout_props
   import tsr_pkg::*;
(
   input wire logic                    clk,
   input wire logic                    sys_rst,
   input wire logic                    scl_in,
   input wire logic                    sda_in,
   input wire tsr_pkg::tsr_sda_type    sda_drive,
   input wire logic [2:0]              strap_address_pins,
   input wire logic [15:0]             config_word,
   input wire tsr_pkg::tsr_sample_type sample_in,
   input wire logic                    conv_request,
   input wire logic [15:0]             temperature_result,
   input wire logic [7:0]              selector
);
   logic        bus_on_ff, nxt_bus_on, sda_d_ff;
   logic [15:0] exp_ff, nxt_exp;
   default clocking cb @(posedge clk); endclocking
   // -------------------------------------------------
   // Bus activity and expected load value
   // -------------------------------------------------
   always_comb begin
      nxt_bus_on = bus_on_ff;
      if (scl_in && sda_d_ff && !sda_in) nxt_bus_on = 1'b1;
      if (scl_in && !sda_d_ff && sda_in) nxt_bus_on = 1'b0;
      nxt_exp = exp_ff;
      if (sample_in.valid) nxt_exp = {sample_in.value, 4'h0}
         & (16'hffff << (3'd7 - {1'b0, config_word[14:13]}));
   end
   always_ff @(posedge clk) begin
      sda_d_ff  <= sda_in;
      exp_ff    <= nxt_exp;
      bus_on_ff <= sys_rst ? 1'b0 : nxt_bus_on;
   end
   // -------------------------------------------------
   // Assertions
   // -------------------------------------------------
   rst_clears_a: assert property (sys_rst |=> temperature_result == 16'h0
      && selector == 8'h00 && sda_drive.oe_n) else $error("reset state");
   boot_conv_a: assert property (disable iff (sys_rst) $fell(sys_rst)
      |=> conv_request) else $error("no boot conversion");
   active_follow_a: assert property (disable iff (sys_rst) !$past(sys_rst)
      |=> conv_request == !$past(config_word[CFG_PWRDN_BIT]))
      else $error("conversion request level");
   load_idle_a: assert property (disable iff (sys_rst)
      sample_in.valid && !bus_on_ff |-> ##[1:2] temperature_result == exp_ff)
      else $error("result not loaded");
   sel_hold_a: assert property (disable iff (sys_rst)
      !bus_on_ff && $past(!bus_on_ff) |-> $stable(selector))
      else $error("selector moved");
   idle_release_a: assert property (disable iff (sys_rst)
      (!bus_on_ff)[*3] |-> sda_drive.oe_n) else $error("data held idle");
   ack_timing_a: assert property (disable iff (sys_rst)
      $fell(sda_drive.oe_n) |-> !scl_in && ($past(scl_in, 2)
      || $past(scl_in, 3))) else $error("drive off clock fall");
   drive_out_a: assert property (disable iff (sys_rst)
      !sda_drive.oe_n |-> bus_on_ff && sda_drive.out == 1'b0)
      else $error("data pin pulled outside a transfer");
   cover property (disable iff (sys_rst) sample_in.valid && bus_on_ff);
   cover property (disable iff (sys_rst) $fell(sda_drive.oe_n));
   cover property (disable iff (sys_rst) $changed(selector));
endmodule : tsr_readout_props
bind tsr_readout tsr_readout_props u_props (.clk, .sys_rst, .scl_in,
   .sda_in, .sda_drive, .strap_address_pins, .config_word, .sample_in,
   .conv_request, .temperature_result, .selector);
`default_nettype wire

// ==== tsr_master.sv ====
// Two-wire bus master model: clock and open-drain data pull
`timescale 1ns/1ps
`default_nettype none
module tsr_master (
   input  wire logic clk,
   input  wire logic sda_w,
   output var  logic scl,
   output var  logic pull
);
   initial begin
      scl  = 1'b1;
      pull = 1'b0;
   end
   task automatic half;
      repeat (4) @(posedge clk);
   endtask : half
   task automatic bit_x(input logic b, output logic r);
      pull <= !b;
      half;
      scl <= 1'b1;
      half;
      r = sda_w;
      scl <= 1'b0;
      half;
   endtask : bit_x
   task automatic start;
      pull <= 1'b0;
      half;
      scl <= 1'b1;
      half;
      pull <= 1'b1;
      half;
      scl <= 1'b0;
      half;
   endtask : start
   task automatic stop;
      pull <= 1'b1;
      half;
      scl <= 1'b1;
      half;
      pull <= 1'b0;
      half;
   endtask : stop
   task automatic put_byte(input logic [7:0] d, output logic ack_n);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, ack_n);
   endtask : put_byte
   task automatic get_byte(input logic ack_n, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(ack_n, r);
   endtask : get_byte
endmodule : tsr_master
`default_nettype wire

// ==== tsr_readout_bench.sv ====
// Self-checking bench for the temperature result readout
`timescale 1ns/1ps
`default_nettype none
module tsr_readout_bench;
   import tsr_pkg::*;
   logic           clk = 1'b0, sys_rst = 1'b1, scl, pull, sda_w, ak, cr;
   logic [2:0]     strap = 3'h0;
   logic [15:0]    cfg = 16'h6000, res, model = 16'h0, pend;
   logic [7:0]     sel, hi, lo;
   tsr_sample_type smp = '0;
   tsr_sda_type    drv;
   int             fails = 0, n_checks = 0, seed = 3;
   always #5 clk = ~clk;
   assign sda_w = !(pull || !drv.oe_n);
   tsr_readout i_dut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
      .sda_in(sda_w), .sda_drive(drv), .strap_address_pins(strap),
      .config_word(cfg), .sample_in(smp), .conv_request(cr),
      .temperature_result(res), .selector(sel));
   tsr_master u_m (.clk(clk), .sda_w(sda_w), .scl(scl), .pull(pull));
   task automatic wrap_up;
      if (fails == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task automatic cmp_word(input string nm, input logic [15:0] e, g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_word
   task automatic cmp_ack(input string nm, input logic e, g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s expected %b seen %b", nm, e, g);
      end
   endtask : cmp_ack
   task automatic conv(input logic [11:0] v, input logic busy);
      @(posedge clk);
      smp <= '{1'b1, v};
      @(posedge clk);
      smp.valid <= 1'b0;
      pend = {v, 4'h0} & (16'hffff << (3'd7 - {1'b0, cfg[14:13]}));
      if (!busy) model = pend;
      repeat (3) @(posedge clk);
   endtask : conv
   task automatic addr(input logic [2:0] a, input logic rw, e);
      u_m.start;
      u_m.put_byte({DEV_ADDR_FIXED, a, rw}, ak);
      cmp_ack("address ack", e, ak);
   endtask : addr
   task automatic rd(input int words, input logic half_only,
                     input logic [15:0] e);
      addr(strap, 1'b1, 1'b0);
      for (int w = 0; w < words; w++) begin
         u_m.get_byte(half_only, hi);
         cmp_word("upper byte", {8'h0, e[15:8]}, {8'h0, hi});
         if (!half_only) begin
            u_m.get_byte(w == words - 1, lo);
            cmp_word("lower byte", {8'h0, e[7:0]}, {8'h0, lo});
         end
      end
      u_m.stop;
      repeat (20) @(posedge clk);
   endtask : rd
   task automatic wr(input logic [7:0] s, input logic e);
      addr(strap, 1'b0, 1'b0);
      u_m.put_byte(s, ak);
      cmp_ack("selector ack", 1'b0, ak);
      u_m.put_byte(8'ha5, ak);
      cmp_ack("data ack", e, ak);
      u_m.stop;
      cmp_word("selector", {8'h0, s}, {8'h0, sel});
      cmp_word("result kept", model, res);
   endtask : wr
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      wrap_up;
   end
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      strap <= 3'($random(seed));
      repeat (3) @(posedge clk);
      cmp_word("reset result", 16'h0000, res);
      cmp_word("reset selector", 16'h0000, {8'h0, sel});
      cmp_ack("conv request", 1'b1, cr);
      rd(1, 1'b0, 16'h0000);
      for (int r = 0; r < 6; r++) begin
         cfg <= {1'b0, (r > 3) ? 2'h3 : r[1:0], 13'h0};
         conv((r == 4) ? 12'h001 : (r == 5) ? 12'h800
              : 12'($random(seed)), 1'b0);
         cmp_word("result", model, res);
         rd(2, 1'b0, model);
      end
      rd(1, 1'b1, model);
      // Conversion lands in the middle of a read
      addr(strap, 1'b1, 1'b0);
      u_m.get_byte(1'b0, hi);
      conv(12'h7d0, 1'b1);
      cmp_word("held result", model, res);
      u_m.get_byte(1'b1, lo);
      u_m.stop;
      cmp_word("snapshot", model, {hi, lo});
      model = pend;
      repeat (3) @(posedge clk);
      cmp_word("late load", model, res);
      addr(~strap, 1'b1, 1'b1);
      u_m.stop;
      wr(8'h00, 1'b1);
      wr(8'h01, 1'b0);
      rd(2, 1'b0, 16'h0000);
      wr(8'h00, 1'b1);
      rd(1, 1'b0, model);
      cfg <= 16'h0100;
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      cmp_ack("boot request", 1'b1, cr);
      repeat (4) @(posedge clk);
      cmp_ack("conv request", 1'b0, cr);
      cmp_word("reset again", 16'h0000, res);
      wrap_up;
   end
endmodule : tsr_readout_bench
`default_nettype wire
